// *** phy_stat_pkg.sv ***
// Register map, field positions and reset values for the status and enable bank
package phy_stat_pkg;
	localparam int          REG_AW            = 5;
	localparam int          REG_DW            = 16;
	localparam int          EVT_N             = 16;
	// Register offsets
	localparam logic [4:0]  OFF_LINK_REPORT   = 5'h11;
	localparam logic [4:0]  OFF_IRQ_ENABLE    = 5'h12;
	localparam logic [4:0]  OFF_EVT_STATUS    = 5'h13;
	localparam logic [4:0]  OFF_EVT_CLEAR     = 5'h1c;
	// Reset values
	localparam logic [15:0] RST_LINK_REPORT   = 16'h0000;
	localparam logic [15:0] RST_IRQ_ENABLE    = 16'h0000;
	localparam logic [15:0] RST_EVT_STATUS    = 16'h0000;
	// Status field positions
	localparam int          POS_SPEED_HI      = 15;
	localparam int          POS_SPEED_LO      = 14;
	localparam int          POS_DUPLEX        = 13;
	localparam int          POS_PAGE_RX       = 12;
	localparam int          POS_SETTLED       = 11;
	localparam int          POS_LINK_UP       = 10;
	localparam int          POS_XOVER_CD      = 9;
	localparam int          POS_XOVER_AB      = 8;
	localparam int          POS_DOWNSHIFT     = 7;
	localparam int          POS_SLEEP         = 6;
	localparam int          POS_POL_HI        = 5;
	localparam int          POS_POL_LO        = 2;
	localparam int          POS_TEN_POL       = 1;
	localparam int          POS_JABBER        = 0;
	// Speed codes; code 2'h3 is never reported
	localparam logic [1:0]  SPD_10            = 2'h0;
	localparam logic [1:0]  SPD_100           = 2'h1;
	localparam logic [1:0]  SPD_1000          = 2'h2;
	localparam logic [1:0]  SPD_RSVD          = 2'h3;
	// Event bit positions in the enable and status words
	localparam int          EV_NEG_FAULT      = 15;
	localparam int          EV_SPEED          = 14;
	localparam int          EV_DUPLEX         = 13;
	localparam int          EV_PAGE_RX        = 12;
	localparam int          EV_NEG_DONE       = 11;
	localparam int          EV_LINK           = 10;
	localparam int          EV_EEE            = 9;
	localparam int          EV_FALSE_CARRIER  = 8;
	localparam int          EV_ADC_FIFO       = 7;
	localparam int          EV_XOVER          = 6;
	localparam int          EV_DOWNSHIFT      = 5;
	localparam int          EV_SLEEP          = 4;
	localparam int          EV_WAKE_PACKET    = 3;
	localparam int          EV_MAC_BUFFER     = 2;
	localparam int          EV_POLARITY       = 1;
	localparam int          EV_JABBER         = 0;
endpackage

// *** sticky_latch.sv ***
// One latched-high bit: event sets it, a clear drops it, and the set wins
module sticky_latch (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic set_in,
	input  wire logic clr_in,
	output logic      flag_q
);
	typedef struct packed {
		logic flag;
	} latch_state_t;

	latch_state_t st_q;
	latch_state_t st_d;

	// Set has priority over a clear in the same cycle
	always_comb begin
		st_d = st_q;
		if (set_in) begin
			st_d.flag = 1'b1;
		end else if (clr_in) begin
			st_d.flag = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flag_q = st_q.flag;

	property p_set_wins;
		@(posedge core_clk) disable iff (rst) set_in |=> flag_q;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("latched bit lost an event");
endmodule

// *** link_state_report_and_irq_enable_regs.sv ***
// Link state report, event enable, event status and interrupt for the PHY management space
// What this block does
// - Bits 15:14 report speed: 00 ten, 01 hundred, 10 gigabit; 11 never.
// - Bit 13 reads one for full duplex, zero for half duplex.
// - Bit 12 latches a received page until the status word is read.
// - Bit 11 is one when negotiation finished or is off.
// - Bit 10 follows the live link state.
// - Bit 7 shows gigabit abilities masked by downshift during negotiation only.
// - Bit 6 is one while the device sleeps.
// - Bits 5:2 flag reversed polarity for channels D, C, B, A.
// - Bit 1 is one for normal ten-megabit receive polarity.
// - Bit 0 is one while jabber is present.
// - Status word resets to zero and ignores writes.
// - Interrupt rises when an event occurs and its enable bit is set.
// - Enable bits are read-write, one enables, all zero after reset.
// - Enable bits 15 down to 0 map to the sixteen listed events.
// - Event status sets regardless of enable and clears when read.
module link_state_report_and_irq_enable_regs (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic [phy_stat_pkg::REG_AW-1:0] reg_addr,
	input  wire logic [phy_stat_pkg::REG_DW-1:0] reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [phy_stat_pkg::REG_DW-1:0]      reg_rdata,
	input  wire logic [1:0]               speed_code,
	input  wire logic                     full_half_indicator,
	input  wire logic                     page_rx_pulse,
	input  wire logic                     negotiation_settled,
	input  wire logic                     link_up,
	input  wire logic                     crossover_state_pairs_cd,
	input  wire logic                     crossover_state_pairs_ab,
	input  wire logic                     negotiating,
	input  wire logic                     downshift_masking_active,
	input  wire logic                     sleep_active,
	input  wire logic [3:0]               channel_polarity_reversed,
	input  wire logic                     ten_pol_normal,
	input  wire logic                     overlong_tx_detected,
	input  wire logic [phy_stat_pkg::EVT_N-1:0]  event_pulse,
	output logic [phy_stat_pkg::EVT_N-1:0]       event_irq_enable,
	output logic                          irq
);
	import phy_stat_pkg::*;

	// Every flip-flop of the bank apart from the sticky latches
	typedef struct packed {
		logic [EVT_N-1:0]  enable;
		logic [REG_DW-1:0] rdata;
		logic              sync1;
		logic              sync2;
		logic              sync3;
		logic              page_lvl;
	} bank_state_t;

	bank_state_t st_q;
	bank_state_t st_d;

	logic [REG_DW-1:0] live_word;
	logic [EVT_N-1:0]  evt_status;
	logic              page_flag;
	logic              rd_report;
	logic              rd_status;
	logic              wr_clear;
	logic [EVT_N-1:0]  evt_clr;
	logic              page_set;

	// Access decode
	always_comb begin
		rd_report = 1'b0;
		rd_status = 1'b0;
		wr_clear  = 1'b0;
		if (reg_rd && reg_addr == OFF_LINK_REPORT) begin
			rd_report = 1'b1;
		end else if (reg_rd && reg_addr == OFF_EVT_STATUS) begin
			rd_status = 1'b1;
		end else if (reg_wr && reg_addr == OFF_EVT_CLEAR) begin
			wr_clear = 1'b1;
		end
	end

	// Clear on read of the status word, or by a one written to the clear word
	assign evt_clr = rd_status ? {EVT_N{1'b1}} : (wr_clear ? reg_wdata : '0);

	// A new page counts once stages two and three agree high after an agreed low level
	assign page_set = st_q.sync2 & st_q.sync3 & ~st_q.page_lvl;

	// Page-received latch: a read of the report clears it, a page in that cycle wins
	sticky_latch u_page_latch (
		.core_clk (core_clk),
		.rst      (rst),
		.set_in   (page_set),
		.clr_in   (rd_report),
		.flag_q   (page_flag)
	);

	// Latched event status, one latch per event, set even when disabled
	genvar gi;
	generate
		for (gi = 0; gi < EVT_N; gi++) begin : g_evt
			sticky_latch u_evt (
				.core_clk (core_clk),
				.rst      (rst),
				.set_in   (event_pulse[gi]),
				.clr_in   (evt_clr[gi]),
				.flag_q   (evt_status[gi])
			);
		end
	endgenerate

	// Live status word assembly
	always_comb begin
		live_word                          = RST_LINK_REPORT;
		live_word[POS_SPEED_HI:POS_SPEED_LO] = (speed_code == SPD_RSVD) ? SPD_10 : speed_code;
		live_word[POS_DUPLEX]              = full_half_indicator;
		live_word[POS_PAGE_RX]             = page_flag;
		live_word[POS_SETTLED]             = negotiation_settled;
		live_word[POS_LINK_UP]             = link_up;
		live_word[POS_XOVER_CD]            = crossover_state_pairs_cd;
		live_word[POS_XOVER_AB]            = crossover_state_pairs_ab;
		live_word[POS_DOWNSHIFT]           = negotiating & downshift_masking_active;
		live_word[POS_SLEEP]               = sleep_active;
		live_word[POS_POL_HI:POS_POL_LO]   = channel_polarity_reversed;
		live_word[POS_TEN_POL]             = ten_pol_normal;
		live_word[POS_JABBER]              = overlong_tx_detected;
	end

	// Register next state: page synchroniser, enable writes, read data
	always_comb begin
		st_d       = st_q;
		st_d.rdata = '0;
		st_d.sync1 = page_rx_pulse;
		st_d.sync2 = st_q.sync1;
		st_d.sync3 = st_q.sync2;
		// The agreed level only moves when stages two and three agree
		if (st_q.sync2 == st_q.sync3) begin
			st_d.page_lvl = st_q.sync3;
		end
		if (reg_wr && reg_addr == OFF_IRQ_ENABLE) begin
			st_d.enable = reg_wdata;
		end
		// The report is read live, so the page bit returned is the one that the read clears
		if (reg_rd && reg_addr == OFF_LINK_REPORT) begin
			st_d.rdata = live_word;
		end else if (reg_rd && reg_addr == OFF_IRQ_ENABLE) begin
			st_d.rdata = st_q.enable;
		end else if (reg_rd && reg_addr == OFF_EVT_STATUS) begin
			st_d.rdata = evt_status;
		end
	end

	// State register; the reset branch loads constants only
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q.enable   <= RST_IRQ_ENABLE;
			st_q.rdata    <= RST_LINK_REPORT;
			st_q.sync1    <= 1'b0;
			st_q.sync2    <= 1'b0;
			st_q.sync3    <= 1'b0;
			st_q.page_lvl <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs: read data and enables from flip-flops, interrupt as a gated OR
	assign reg_rdata        = st_q.rdata;
	assign event_irq_enable = st_q.enable;
	assign irq              = |(evt_status & st_q.enable);

	// The reserved speed code never reaches the bus
	property p_speed_never_rsvd;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_SPEED_HI:POS_SPEED_LO] != SPD_RSVD;
	endproperty
	a_speed_never_rsvd: assert property (p_speed_never_rsvd)
		else $error("reserved speed code read");

	// A legal speed code is reported as it stands
	property p_speed_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report && speed_code != SPD_RSVD
			|=> reg_rdata[POS_SPEED_HI:POS_SPEED_LO] == $past(speed_code);
	endproperty
	a_speed_follows: assert property (p_speed_follows)
		else $error("speed field wrong");

	// Duplex bit follows the live duplex level
	property p_duplex_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_DUPLEX] == $past(full_half_indicator);
	endproperty
	a_duplex_follows: assert property (p_duplex_follows)
		else $error("duplex bit stale");

	// A detected page sets the latch
	property p_page_latches;
		@(posedge core_clk) disable iff (rst)
			page_set |=> page_flag;
	endproperty
	a_page_latches: assert property (p_page_latches)
		else $error("page not latched");

	// A latched page is returned by the read that clears it
	property p_page_reads;
		@(posedge core_clk) disable iff (rst)
			rd_report && page_flag |=> reg_rdata[POS_PAGE_RX];
	endproperty
	a_page_reads: assert property (p_page_reads)
		else $error("latched page not read");

	// A read of the report clears the page bit unless a new page arrives
	property p_page_clear_on_read;
		@(posedge core_clk) disable iff (rst)
			rd_report && !page_set |=> !page_flag;
	endproperty
	a_page_clear_on_read: assert property (p_page_clear_on_read)
		else $error("page bit not cleared");

	// Negotiation-settled bit follows its level
	property p_settled_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_SETTLED] == $past(negotiation_settled);
	endproperty
	a_settled_follows: assert property (p_settled_follows)
		else $error("settled bit stale");

	// Link bit follows the live link level
	property p_link_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_LINK_UP] == $past(link_up);
	endproperty
	a_link_follows: assert property (p_link_follows)
		else $error("link bit stale");

	// Crossover bits follow their levels
	property p_xover_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_XOVER_CD] == $past(crossover_state_pairs_cd)
				&& reg_rdata[POS_XOVER_AB] == $past(crossover_state_pairs_ab);
	endproperty
	a_xover_follows: assert property (p_xover_follows)
		else $error("crossover bits stale");

	// Downshift bit stays low outside negotiation
	property p_downshift_only_neg;
		@(posedge core_clk) disable iff (rst)
			rd_report && !negotiating |=> !reg_rdata[POS_DOWNSHIFT];
	endproperty
	a_downshift_only_neg: assert property (p_downshift_only_neg)
		else $error("downshift outside negotiation");

	// Sleep bit follows the power state
	property p_sleep_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_SLEEP] == $past(sleep_active);
	endproperty
	a_sleep_follows: assert property (p_sleep_follows)
		else $error("sleep bit stale");

	// Channel polarity bits follow their levels, D at the top
	property p_polarity_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_POL_HI:POS_POL_LO] == $past(channel_polarity_reversed);
	endproperty
	a_polarity_follows: assert property (p_polarity_follows)
		else $error("channel polarity stale");

	// Ten-megabit polarity bit reads one for normal polarity
	property p_ten_pol_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_TEN_POL] == $past(ten_pol_normal);
	endproperty
	a_ten_pol_follows: assert property (p_ten_pol_follows)
		else $error("ten polarity stale");

	// Jabber bit follows its level
	property p_jabber_follows;
		@(posedge core_clk) disable iff (rst)
			rd_report |=> reg_rdata[POS_JABBER] == $past(overlong_tx_detected);
	endproperty
	a_jabber_follows: assert property (p_jabber_follows)
		else $error("jabber bit stale");

	// Read data is zero outside the answer cycle
	property p_rdata_idle;
		@(posedge core_clk) disable iff (rst)
			!reg_rd |=> reg_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not idle");

	// Unmapped offsets read as zero
	property p_unmapped_read;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr != OFF_LINK_REPORT && reg_addr != OFF_IRQ_ENABLE
				&& reg_addr != OFF_EVT_STATUS |=> reg_rdata == '0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read not zero");

	// A write to the enable word lands in the next cycle
	property p_enable_write;
		@(posedge core_clk) disable iff (rst)
			reg_wr && reg_addr == OFF_IRQ_ENABLE |=> event_irq_enable == $past(reg_wdata);
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("enable write lost");

	// The enable word changes only by a write to it
	property p_enable_holds;
		@(posedge core_clk) disable iff (rst)
			!(reg_wr && reg_addr == OFF_IRQ_ENABLE) |=> $stable(event_irq_enable);
	endproperty
	a_enable_holds: assert property (p_enable_holds)
		else $error("enable word changed");

	// Enable read returns the enable word
	property p_enable_read;
		@(posedge core_clk) disable iff (rst)
			reg_rd && reg_addr == OFF_IRQ_ENABLE |=> reg_rdata == $past(event_irq_enable);
	endproperty
	a_enable_read: assert property (p_enable_read)
		else $error("enable read wrong");

	// An enabled event raises the interrupt in the next cycle
	property p_irq_rises;
		@(posedge core_clk) disable iff (rst)
			(event_pulse & event_irq_enable) != '0 && !(reg_wr && reg_addr == OFF_IRQ_ENABLE)
			|=> irq;
	endproperty
	a_irq_rises: assert property (p_irq_rises)
		else $error("enabled event gave no irq");

	// Every event bit latches, enabled or not
	property p_event_latches;
		@(posedge core_clk) disable iff (rst)
			event_pulse != '0 |=> (evt_status & $past(event_pulse)) == $past(event_pulse) [*1];
	endproperty
	a_event_latches: assert property (p_event_latches)
		else $error("event not latched");

	// A read of the event status clears it when no event arrives
	property p_status_read_clears;
		@(posedge core_clk) disable iff (rst)
			rd_status && event_pulse == '0 |=> evt_status == '0;
	endproperty
	a_status_read_clears: assert property (p_status_read_clears)
		else $error("status not cleared by read");

	// Ones written to the clear word drop those bits
	property p_clear_write;
		@(posedge core_clk) disable iff (rst)
			wr_clear && (event_pulse & reg_wdata) == '0
			|=> (evt_status & $past(reg_wdata)) == '0;
	endproperty
	a_clear_write: assert property (p_clear_write)
		else $error("clear write ignored");

	// The interrupt stays up while nothing clears and the enables hold
	property p_irq_holds;
		@(posedge core_clk) disable iff (rst)
			irq && !rd_status && !wr_clear && !(reg_wr && reg_addr == OFF_IRQ_ENABLE) |=> irq;
	endproperty
	a_irq_holds: assert property (p_irq_holds)
		else $error("irq dropped early");

	// Clearing every pending bit drops the interrupt
	property p_read_clears_irq;
		@(posedge core_clk) disable iff (rst)
			rd_status && event_pulse == '0 |=> !irq;
	endproperty
	a_read_clears_irq: assert property (p_read_clears_irq)
		else $error("irq stuck after clear");
endmodule

// *** link_state_report_and_irq_enable_regs_test.sv ***
// Self-checking bench for the link report, event enable and event status registers
module link_state_report_and_irq_enable_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import phy_stat_pkg::*;
	logic        core_clk         = 1'b0;
	logic        rst              = 1'b1;
	logic [4:0]  reg_addr         = '0;
	logic [15:0] reg_wdata        = '0;
	logic        reg_wr           = 1'b0;
	logic        reg_rd           = 1'b0;
	logic [15:0] reg_rdata;
	logic [1:0]  speed_code       = '0;
	logic [9:0]  lv               = '0; // Live status levels, one per input
	logic [3:0]  pol_rev          = '0;
	logic        page_rx_pulse    = 1'b0;
	logic [15:0] event_pulse      = '0;
	logic [15:0] event_irq_enable;
	logic        irq;
	int          miscompares      = 0;
	int          cmp_count        = 0;
	int          seed             = 98;
	logic [15:0] m_en;
	logic [15:0] m_st;
	logic [15:0] got;

	link_state_report_and_irq_enable_regs dut (
		.core_clk                 (core_clk),
		.rst                      (rst),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.speed_code               (speed_code),
		.full_half_indicator      (lv[0]),
		.page_rx_pulse            (page_rx_pulse),
		.negotiation_settled      (lv[1]),
		.link_up                  (lv[2]),
		.crossover_state_pairs_cd (lv[3]),
		.crossover_state_pairs_ab (lv[4]),
		.negotiating              (lv[5]),
		.downshift_masking_active (lv[6]),
		.sleep_active             (lv[7]),
		.channel_polarity_reversed(pol_rev),
		.ten_pol_normal           (lv[8]),
		.overlong_tx_detected     (lv[9]),
		.event_pulse              (event_pulse),
		.event_irq_enable         (event_irq_enable),
		.irq                      (irq)
	);

	// Free-running 25 MHz clock
	always #20 core_clk = ~core_clk;

	// Expected report word from the live levels; speed code 3 reads as ten
	function automatic logic [15:0] exp_rep(input logic pg);
		logic [1:0] s;
		s = (speed_code == SPD_RSVD) ? SPD_10 : speed_code;
		return {s, lv[0], pg, lv[1], lv[2], lv[3], lv[4], lv[5] & lv[6], lv[7], pol_rev, lv[8], lv[9]};
	endfunction

	// Compare and count
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle register read, data taken in the answer cycle
	task automatic rd(input logic [4:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		got = reg_rdata;
	endtask

	// Verdict and end of run
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (6000) @(posedge core_clk);
		miscompares++;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rd(OFF_LINK_REPORT);
		chk(got, 16'h0000);
		rd(OFF_IRQ_ENABLE);
		chk(got, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		// Random live levels; writes to the report word must not stick
		repeat (40) begin
			@(posedge core_clk);
			speed_code <= 2'($random(seed));
			lv <= 10'($random(seed));
			pol_rev <= 4'($random(seed));
			wr(OFF_LINK_REPORT, 16'($random(seed)));
			rd(OFF_LINK_REPORT);
			chk(got, exp_rep(1'b0));
		end
		rd(5'h05);
		chk(got, 16'h0000);
		// Enable word read-back
		repeat (8) begin
			m_en = 16'($random(seed));
			wr(OFF_IRQ_ENABLE, m_en);
			@(negedge core_clk);
			chk(event_irq_enable, m_en);
			rd(OFF_IRQ_ENABLE);
			chk(got, m_en);
		end
		// Every event, once enabled and once masked
		for (int p = 0; p < 2; p++) begin
			m_en = p ? 16'ha5a5 : 16'h5a5a;
			wr(OFF_IRQ_ENABLE, m_en);
			for (int i = 0; i < 16; i++) begin
				m_st = 16'(32'h1 << i);
				@(posedge core_clk);
				event_pulse <= m_st;
				@(posedge core_clk);
				event_pulse <= '0;
				@(negedge core_clk);
				chk({15'h0, irq}, {15'h0, m_en[i]});
				rd(OFF_EVT_STATUS);
				chk(got, m_st);
				chk({15'h0, irq}, 16'h0000);
			end
		end
		// Two pending events: the interrupt holds until both are cleared
		wr(OFF_IRQ_ENABLE, 16'h8001);
		@(posedge core_clk);
		event_pulse <= 16'h8001;
		@(posedge core_clk);
		event_pulse <= '0;
		wr(OFF_EVT_CLEAR, 16'h0001);
		@(negedge core_clk);
		chk({15'h0, irq}, 16'h0001);
		wr(OFF_EVT_CLEAR, 16'h8000);
		@(negedge core_clk);
		chk({15'h0, irq}, 16'h0000);
		rd(OFF_EVT_STATUS);
		chk(got, 16'h0000);
		// Received page latches until the report word is read
		@(posedge core_clk);
		page_rx_pulse <= 1'b1;
		repeat (8) @(posedge core_clk);
		page_rx_pulse <= 1'b0;
		rd(OFF_LINK_REPORT);
		chk(got, exp_rep(1'b1));
		rd(OFF_LINK_REPORT);
		chk(got, exp_rep(1'b0));
		@(negedge core_clk);
		chk(reg_rdata, 16'h0000);
		// Reset in mid-run drops enables, pending events and the interrupt
		wr(OFF_IRQ_ENABLE, 16'hffff);
		@(posedge core_clk);
		event_pulse <= 16'h0400;
		@(posedge core_clk);
		event_pulse <= '0;
		@(negedge core_clk);
		chk({15'h0, irq}, 16'h0001);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		chk(event_irq_enable, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		rd(OFF_EVT_STATUS);
		chk(got, 16'h0000);
		close_out();
	end
endmodule
